// [jrl_pkg.sv]
// package: types and constants for the register jump and load unit
//
// Behaviour
// RL1: link jump redirects after delay, links PC+8
// RL2: assembler defaults link register to r31
// RL3: equal source and link registers not trapped
// RL4: misaligned jump target faults at fetch
// RL5: plain register jump redirects next cycle, no write
// RL6: address is base plus sign-extended offset
// RL7: signed byte load sign-extends the byte
// RL8: unsigned byte load zero-extends the byte
// RL9: doubleword load writes all 64 bits
// RL10: doubleword load faults on low three bits
// RL11: coprocessor doubleword load hands data, checks alignment
// RL12: software never targets system control coprocessor
// RL13: software keeps target field lowest bit zero
// RL14: left unaligned load fills register from top
// RL15: right unaligned load fills register from bottom
// RL16: unaligned loads never raise alignment faults
// RL17: pending load result bypassed to unaligned load
// RL18: unaligned loads send size and byte offset
// RL19: translation or bus faults are precise, no write
package jrl_pkg;
    localparam int XLEN = 64;
    localparam int IMM_W = 16;
    localparam int REG_IDX_W = 5;
    localparam int COP_SEL_W = 2;
    localparam logic [XLEN-1:0] LINK_OFFSET = 64'h0000_0000_0000_0008;
    localparam logic [REG_IDX_W-1:0] LINK_REG_DEFAULT = 5'h1f;
    localparam logic [1:0] INSN_ALIGN_MASK = 2'h3;
    localparam logic [2:0] DWORD_ALIGN_MASK = 3'h7;
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_DWORD = 3'h7;
    localparam logic [XLEN-1:0] DATA_RESET = 64'h0;
    localparam logic [REG_IDX_W-1:0] IDX_RESET = 5'h0;

    typedef enum logic [2:0] {
        OP_JUMP_VIA_REGISTER = 3'h0,
        OP_JUMP_REG_WITH_LINK = 3'h1,
        OP_LOAD_SIGNED_BYTE = 3'h2,
        OP_LOAD_UNSIGNED_BYTE = 3'h3,
        OP_LOAD_DOUBLEWORD = 3'h4,
        OP_LOAD_DWORD_TO_COP = 3'h5,
        OP_UNALIGNED_LOAD_LEFT = 3'h6,
        OP_UNALIGNED_LOAD_RIGHT = 3'h7
    } jrl_op_t;

    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_ADDR_LOAD = 3'h1,
        EXC_TLB_REFILL = 3'h2,
        EXC_TLB_INVALID = 3'h3,
        EXC_BUS = 3'h4
    } jrl_exc_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_MEM_WAIT = 1'b1
    } jrl_state_t;

    typedef struct packed {
        jrl_op_t op;
        logic [XLEN-1:0] pc;
        logic [XLEN-1:0] src_val;
        logic [XLEN-1:0] base_val;
        logic [XLEN-1:0] old_val;
        logic [IMM_W-1:0] offset;
        logic [REG_IDX_W-1:0] dest;
        logic [COP_SEL_W-1:0] cop_sel;
    } jrl_req_t;

    typedef struct packed {
        logic [XLEN-1:0] vaddr;
        logic [2:0] memory_access_size_code;
        logic [2:0] byte_offset;
    } jrl_mreq_t;

    typedef struct packed {
        logic [XLEN-1:0] data;
        logic tlb_refill;
        logic tlb_invalid;
        logic bus_err;
    } jrl_mrsp_t;
endpackage : jrl_pkg

// [jrl_byte_merge.sv]
// unaligned doubleword byte merge for the left and right loads
`timescale 1ns/1ps
module jrl_byte_merge
    import jrl_pkg::*;
(
    input wire logic [XLEN-1:0] mem_in,
    input wire logic [XLEN-1:0] old_in,
    input wire logic [2:0] byte_sel_in,
    input wire logic left_in,
    output logic [XLEN-1:0] result_out
);
    logic [XLEN-1:0] shifted;
    logic [2:0] keep_edge;

    always_comb begin
        keep_edge = 3'h7 - byte_sel_in;
        if (left_in) begin
            shifted = mem_in << {keep_edge, 3'h0};
        end else begin
            shifted = mem_in >> {byte_sel_in, 3'h0};
        end
        for (int lane = 0; lane < 8; lane++) begin
            // left: lanes at or above 7-byte come from memory
            if (left_in ? (3'(lane) >= keep_edge) : (3'(lane) <= keep_edge)) begin
                result_out[lane*8 +: 8] = shifted[lane*8 +: 8]; // RL14 RL15
            end else begin
                result_out[lane*8 +: 8] = old_in[lane*8 +: 8];
            end
        end
    end
endmodule : jrl_byte_merge

// [jrl_jump_load_unit.sv]
// register jump and load execution unit
`timescale 1ns/1ps
module jrl_jump_load_unit
    import jrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire jrl_req_t req_in,
    input wire logic processor_endian_flag_in,
    input wire logic memory_endian_flag_in,
    input wire logic mem_rsp_valid_in,
    input wire jrl_mrsp_t mem_rsp_in,
    output logic ready_out,
    output logic redirect_valid_out,
    output logic [XLEN-1:0] redirect_pc_out,
    output logic target_misaligned_out,
    output logic mem_req_valid_out,
    output jrl_mreq_t mem_req_out,
    output logic wb_valid_out,
    output logic [REG_IDX_W-1:0] wb_idx_out,
    output logic [XLEN-1:0] wb_data_out,
    output logic cop_valid_out,
    output logic [COP_SEL_W-1:0] cop_sel_out,
    output logic [XLEN-1:0] cop_data_out,
    output logic exc_valid_out,
    output jrl_exc_t exc_code_out,
    output logic [XLEN-1:0] bad_vaddr_out
);
    // ==========================================================
    // request decode
    jrl_state_t state_r;
    jrl_op_t op_r;
    logic [2:0] lane_r;
    logic [REG_IDX_W-1:0] dest_r;
    logic [COP_SEL_W-1:0] cop_r;
    logic [XLEN-1:0] old_r;
    logic [XLEN-1:0] vaddr_r;
    logic accept;
    logic is_jump;
    logic is_dword;
    logic is_unal;
    logic dw_misaligned;
    logic issue_mem;
    logic [XLEN-1:0] eff_addr;
    logic [2:0] byte_sel;
    logic fwd_hit;
    logic rsp_done;
    logic rsp_err;
    logic [7:0] lane_byte;
    logic [XLEN-1:0] merged;
    logic [XLEN-1:0] load_result;

    assign accept = req_valid_in && ready_out;
    assign is_jump = (req_in.op == OP_JUMP_VIA_REGISTER) || (req_in.op == OP_JUMP_REG_WITH_LINK);
    assign is_dword = (req_in.op == OP_LOAD_DOUBLEWORD) || (req_in.op == OP_LOAD_DWORD_TO_COP);
    assign is_unal = (req_in.op == OP_UNALIGNED_LOAD_LEFT) ||
        (req_in.op == OP_UNALIGNED_LOAD_RIGHT);
    assign eff_addr = req_in.base_val +
        {{(XLEN-IMM_W){req_in.offset[IMM_W-1]}}, req_in.offset}; // RL6
    assign byte_sel = eff_addr[2:0] ^ {3{processor_endian_flag_in}};
    assign dw_misaligned = is_dword && ((eff_addr[2:0] & DWORD_ALIGN_MASK) != 3'h0); // RL10 RL11
    // unaligned loads stay inside one doubleword, so no alignment check
    assign issue_mem = accept && !is_jump && !dw_misaligned; // RL16
    // r0 never holds a written value, so never forward into it
    assign fwd_hit = wb_valid_out && (wb_idx_out == req_in.dest) && (req_in.dest != 5'h0);
    assign rsp_done = (state_r == ST_MEM_WAIT) && mem_rsp_valid_in;
    assign rsp_err = mem_rsp_in.tlb_refill || mem_rsp_in.tlb_invalid || mem_rsp_in.bus_err;
    assign lane_byte = mem_rsp_in.data[{lane_r, 3'h0} +: 8];

    // ==========================================================
    // unaligned merge and result select
    jrl_byte_merge u_merge (
        .mem_in(mem_rsp_in.data),
        .old_in(old_r),
        .byte_sel_in(lane_r),
        .left_in(op_r == OP_UNALIGNED_LOAD_LEFT),
        .result_out(merged)
    );

    always_comb begin
        unique case (op_r)
            OP_LOAD_SIGNED_BYTE: load_result = {{(XLEN-8){lane_byte[7]}}, lane_byte}; // RL7
            OP_LOAD_UNSIGNED_BYTE: load_result = {{(XLEN-8){1'b0}}, lane_byte}; // RL8
            OP_UNALIGNED_LOAD_LEFT, OP_UNALIGNED_LOAD_RIGHT: load_result = merged;
            default: load_result = mem_rsp_in.data; // RL9
        endcase
    end

    // ==========================================================
    // sequencing
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= ST_IDLE;
            ready_out <= 1'b1;
        end else if (issue_mem) begin
            state_r <= ST_MEM_WAIT;
            ready_out <= 1'b0;
        end else if (rsp_done) begin
            state_r <= ST_IDLE;
            ready_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            op_r <= OP_JUMP_VIA_REGISTER;
            lane_r <= 3'h0;
            dest_r <= IDX_RESET;
            cop_r <= '0;
            old_r <= DATA_RESET;
            vaddr_r <= DATA_RESET;
        end else if (issue_mem) begin
            op_r <= req_in.op;
            lane_r <= byte_sel;
            dest_r <= req_in.dest;
            cop_r <= req_in.cop_sel;
            old_r <= fwd_hit ? wb_data_out : req_in.old_val; // RL17
            vaddr_r <= eff_addr;
        end
    end

    // ==========================================================
    // jump redirect: target taken now, applied one cycle later
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            redirect_valid_out <= 1'b0;
            redirect_pc_out <= DATA_RESET;
            target_misaligned_out <= 1'b0;
        end else begin
            redirect_valid_out <= accept && is_jump; // RL1 RL5
            if (accept && is_jump) begin
                redirect_pc_out <= req_in.src_val;
                // fault belongs to the fetch of the target, flagged alongside it
                target_misaligned_out <= (req_in.src_val[1:0] & INSN_ALIGN_MASK) != 2'h0; // RL4
            end
        end
    end

    // ==========================================================
    // memory request
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mem_req_valid_out <= 1'b0;
            mem_req_out <= '0;
        end else begin
            mem_req_valid_out <= issue_mem;
            if (issue_mem) begin
                mem_req_out.vaddr <= eff_addr;
                unique case (req_in.op)
                    OP_UNALIGNED_LOAD_LEFT: begin
                        mem_req_out.memory_access_size_code <= byte_sel; // RL18
                        mem_req_out.byte_offset <= memory_endian_flag_in ? ~byte_sel : 3'h0;
                    end
                    OP_UNALIGNED_LOAD_RIGHT: begin
                        mem_req_out.memory_access_size_code <= ~byte_sel; // RL18
                        mem_req_out.byte_offset <= memory_endian_flag_in ? 3'h0 : byte_sel;
                    end
                    OP_LOAD_SIGNED_BYTE, OP_LOAD_UNSIGNED_BYTE: begin
                        mem_req_out.memory_access_size_code <= SIZE_BYTE;
                        mem_req_out.byte_offset <= eff_addr[2:0];
                    end
                    default: begin
                        mem_req_out.memory_access_size_code <= SIZE_DWORD;
                        mem_req_out.byte_offset <= 3'h0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // register write back, coprocessor hand-off
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wb_valid_out <= 1'b0;
            wb_idx_out <= IDX_RESET;
            wb_data_out <= DATA_RESET;
        end else if (accept && req_in.op == OP_JUMP_REG_WITH_LINK) begin
            // equal source and link indexes are not checked: no trap
            wb_valid_out <= 1'b1; // RL1 RL3
            wb_idx_out <= req_in.dest;
            wb_data_out <= req_in.pc + LINK_OFFSET;
        end else if (rsp_done && !rsp_err && op_r != OP_LOAD_DWORD_TO_COP) begin
            wb_valid_out <= 1'b1;
            wb_idx_out <= dest_r;
            wb_data_out <= load_result;
        end else begin
            wb_valid_out <= 1'b0; // RL19
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cop_valid_out <= 1'b0;
            cop_sel_out <= '0;
            cop_data_out <= DATA_RESET;
        end else begin
            cop_valid_out <= rsp_done && !rsp_err && op_r == OP_LOAD_DWORD_TO_COP; // RL11
            if (rsp_done && op_r == OP_LOAD_DWORD_TO_COP) begin
                cop_sel_out <= cop_r;
                cop_data_out <= mem_rsp_in.data;
            end
        end
    end

    // ==========================================================
    // precise exceptions
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            exc_valid_out <= 1'b0;
            exc_code_out <= EXC_NONE;
            bad_vaddr_out <= DATA_RESET;
        end else if (accept && dw_misaligned) begin
            exc_valid_out <= 1'b1; // RL10
            exc_code_out <= EXC_ADDR_LOAD;
            bad_vaddr_out <= eff_addr;
        end else if (rsp_done && rsp_err) begin
            exc_valid_out <= 1'b1; // RL19
            exc_code_out <= mem_rsp_in.tlb_refill ? EXC_TLB_REFILL :
                mem_rsp_in.tlb_invalid ? EXC_TLB_INVALID : EXC_BUS;
            bad_vaddr_out <= vaddr_r;
        end else begin
            exc_valid_out <= 1'b0;
            exc_code_out <= EXC_NONE;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_take(jrl_op_t o);
        accept && req_in.op == o;
    endsequence
    sequence s_good_rsp(jrl_op_t o);
        rsp_done && !rsp_err && op_r == o;
    endsequence

    a_link_jump_redirect: assert property (s_take(OP_JUMP_REG_WITH_LINK) |=> // RL1
        redirect_valid_out && redirect_pc_out == $past(req_in.src_val) &&
        wb_valid_out && wb_data_out == $past(req_in.pc) + LINK_OFFSET)
        else $error("link jump redirect or link value wrong");
    a_plain_jump_nowrite: assert property (s_take(OP_JUMP_VIA_REGISTER) |=> // RL5
        redirect_valid_out && !wb_valid_out && !mem_req_valid_out)
        else $error("plain jump wrote a register or missed redirect");
    a_target_fault_flag: assert property (redirect_valid_out |-> // RL4
        target_misaligned_out == (redirect_pc_out[1:0] != 2'h0) && !exc_valid_out)
        else $error("target misalignment flag wrong");
    a_dword_align_fault: assert property (accept && dw_misaligned |=> // RL10
        exc_valid_out && exc_code_out == EXC_ADDR_LOAD && !mem_req_valid_out && ready_out)
        else $error("misaligned doubleword not faulted");
    a_unaligned_no_fault: assert property (accept && is_unal |=> // RL16
        mem_req_valid_out && !exc_valid_out)
        else $error("unaligned load did not issue");
    a_vaddr_formed: assert property (issue_mem |=> // RL6
        mem_req_out.vaddr == $past(req_in.base_val) +
        {{48{$past(req_in.offset[15])}}, $past(req_in.offset)})
        else $error("effective address wrong");
    a_signed_byte: assert property (s_good_rsp(OP_LOAD_SIGNED_BYTE) |=> // RL7
        wb_valid_out && wb_data_out[63:8] == {56{wb_data_out[7]}})
        else $error("signed byte not sign extended");
    a_unsigned_byte: assert property (s_good_rsp(OP_LOAD_UNSIGNED_BYTE) |=> // RL8
        wb_valid_out && wb_data_out[63:8] == 56'h0)
        else $error("unsigned byte not zero extended");
    a_dword_full: assert property (s_good_rsp(OP_LOAD_DOUBLEWORD) |=> // RL9
        wb_valid_out && wb_data_out == $past(mem_rsp_in.data))
        else $error("doubleword data wrong");
    a_fault_no_write: assert property (rsp_done && rsp_err |=> // RL19
        exc_valid_out && !wb_valid_out && !cop_valid_out && ready_out)
        else $error("faulting load wrote back");
    a_left_top_byte: assert property (s_good_rsp(OP_UNALIGNED_LOAD_LEFT) |=> // RL14
        wb_data_out[63:56] == $past(mem_rsp_in.data[{lane_r, 3'h0} +: 8]))
        else $error("left load top byte wrong");
    a_right_low_byte: assert property (s_good_rsp(OP_UNALIGNED_LOAD_RIGHT) |=> // RL15
        wb_data_out[7:0] == $past(mem_rsp_in.data[{lane_r, 3'h0} +: 8]))
        else $error("right load low byte wrong");
    a_bypass_used: assert property (issue_mem && is_unal && fwd_hit |=> // RL17
        old_r == $past(wb_data_out))
        else $error("pending result not forwarded");
    a_cop_handoff: assert property (s_good_rsp(OP_LOAD_DWORD_TO_COP) |=> // RL11
        cop_valid_out && !wb_valid_out && cop_data_out == $past(mem_rsp_in.data))
        else $error("coprocessor data not handed over");
endmodule : jrl_jump_load_unit

// [jrl_mem_model.sv]
// memory-side model: answers one load request at a time after a set delay
`timescale 1ns/1ps
module jrl_mem_model
    import jrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire jrl_mreq_t req_in,
    input wire logic [1:0] delay_in,
    input wire logic [2:0] fault_in,
    output logic rsp_valid_out,
    output jrl_mrsp_t rsp_out
);
    logic pend_r;
    logic [1:0] cnt_r;
    logic [2:0] fault_r;
    logic [XLEN-1:0] addr_r;
    logic [XLEN-1:0] last_r;

    function automatic logic [XLEN-1:0] word_at(input logic [XLEN-1:0] a);
        return {a[63:3], 3'h0} ^ {a[34:3], a[63:32]} ^ 64'h0123_4567_89ab_cdef;
    endfunction : word_at

    // ====================================================
    // request capture and delayed answer
    // delay and fault are latched with the request, so the bench may change them afterwards
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pend_r <= 1'b0;
            cnt_r <= 2'h0;
            fault_r <= 3'h0;
            addr_r <= '0;
            last_r <= '0;
            rsp_valid_out <= 1'b0;
        end else begin
            rsp_valid_out <= 1'b0;
            if (req_valid_in) begin
                pend_r <= 1'b1;
                cnt_r <= delay_in;
                fault_r <= fault_in;
                addr_r <= req_in.vaddr;
            end else if (pend_r) begin
                cnt_r <= cnt_r - 2'h1;
                if (cnt_r == 2'h0) begin
                    pend_r <= 1'b0;
                    rsp_valid_out <= 1'b1;
                    last_r <= word_at(addr_r);
                end
            end
        end
    end

    // ====================================================
    // outside the answer the lines carry no stale copy of the data
    always_comb begin
        if (rsp_valid_out) begin
            rsp_out = {word_at(addr_r), fault_r};
        end else begin
            rsp_out = {~last_r, 3'h7};
        end
    end
endmodule : jrl_mem_model

// [testbench.sv]
// self-checking bench for the register jump and load unit
`timescale 1ns/1ps
module testbench
    import jrl_pkg::*;
;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic req_valid_in = 1'b0;
    jrl_req_t req_in = '0;
    logic processor_endian_flag = 1'b0;
    logic memory_endian_flag = 1'b0;
    logic [1:0] mem_delay = 2'h0;
    logic [2:0] mem_fault = 3'h0;
    logic mem_rsp_valid, ready_out, redirect_valid_out, target_misaligned_out, mem_req_valid;
    logic wb_valid_out, cop_valid_out, exc_valid_out;
    jrl_mrsp_t mem_rsp;
    jrl_mreq_t mem_req;
    jrl_exc_t exc_code_out;
    logic [XLEN-1:0] redirect_pc_out, wb_data_out, cop_data_out, bad_vaddr_out;
    logic [REG_IDX_W-1:0] wb_idx_out;
    logic [COP_SEL_W-1:0] cop_sel_out;
    int num_errors = 0;
    int check_count = 0;
    logic [131:0] exp_q[$];
    logic pv = 1'b0;
    logic [4:0] pd = 5'h0;
    logic [63:0] pdat = 64'h0;

    always #50 clk_in = ~clk_in;

    jrl_jump_load_unit u_dut (.clk_in(clk_in), .reset_in(reset_in),
        .req_valid_in(req_valid_in), .req_in(req_in),
        .processor_endian_flag_in(processor_endian_flag),
        .memory_endian_flag_in(memory_endian_flag), .mem_rsp_valid_in(mem_rsp_valid),
        .mem_rsp_in(mem_rsp), .ready_out(ready_out), .redirect_valid_out(redirect_valid_out),
        .redirect_pc_out(redirect_pc_out), .target_misaligned_out(target_misaligned_out),
        .mem_req_valid_out(mem_req_valid), .mem_req_out(mem_req), .wb_valid_out(wb_valid_out),
        .wb_idx_out(wb_idx_out), .wb_data_out(wb_data_out), .cop_valid_out(cop_valid_out),
        .cop_sel_out(cop_sel_out), .cop_data_out(cop_data_out), .exc_valid_out(exc_valid_out),
        .exc_code_out(exc_code_out), .bad_vaddr_out(bad_vaddr_out));

    jrl_mem_model u_mem (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(mem_req_valid),
        .req_in(mem_req), .delay_in(mem_delay), .fault_in(mem_fault),
        .rsp_valid_out(mem_rsp_valid), .rsp_out(mem_rsp));

    // ====================================================
    // checking and verdict
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic push(input int k, input logic [127:0] v);
        exp_q.push_back({4'(k), v});
    endtask : push

    task automatic seen_ev(input int k, input logic [127:0] v);
        if (exp_q.size() == 0 || exp_q[0][131:128] !== 4'(k)) begin
            num_errors++;
            $display("MISMATCH t=%0t unexpected event kind %0d", $time, k);
        end else begin
            check(v, exp_q[0][127:0]);
            void'(exp_q.pop_front());
        end
    endtask : seen_ev

    // outputs are settled at the falling edge; results come strictly in order
    always @(negedge clk_in) begin
        if (!reset_in) begin
            if (redirect_valid_out === 1'b1) begin
                seen_ev(1, {target_misaligned_out, redirect_pc_out});
            end
            if (wb_valid_out === 1'b1) begin
                seen_ev(2, {wb_idx_out, wb_data_out});
            end
            if (mem_req_valid === 1'b1) seen_ev(3, mem_req);
            if (cop_valid_out === 1'b1) seen_ev(4, {cop_sel_out, cop_data_out});
            if (exc_valid_out === 1'b1) seen_ev(5, {exc_code_out,
                (exc_code_out == EXC_BUS) ? 64'h0 : bad_vaddr_out});
        end
    end

    // ====================================================
    // request driving with an integer model of the results
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 50) begin
            req_valid_in = 1'b0;
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n == 50) num_errors++;
    endtask : wait_ready

    task automatic idle(input int n);
        wait_ready();
        req_valid_in = 1'b0;
        pv = 1'b0;
        repeat (n + 1) @(posedge clk_in);
        #1;
    endtask : idle

    task automatic issue(input jrl_op_t op, input logic [4:0] dest, input logic [63:0] a,
                         input logic [15:0] off, input logic [1:0] cs);
        logic [63:0] va, d, old, res;
        logic [2:0] b, sz, mo, f;
        jrl_exc_t e;
        logic busy;
        wait_ready();
        busy = 1'b0;
        f = ($urandom % 4 == 0) ? 3'($urandom) : 3'h0;
        processor_endian_flag = 1'($urandom);
        memory_endian_flag = 1'($urandom);
        mem_delay = 2'($urandom);
        mem_fault = f;
        req_in = '{op, {$urandom, $urandom}, a, a, {$urandom, $urandom}, off, dest, cs};
        va = a + {{48{off[15]}}, off};
        old = (pv && pd == dest && dest != 5'h0) ? pdat : req_in.old_val;
        d = {va[63:3], 3'h0} ^ {va[34:3], va[63:32]} ^ 64'h0123_4567_89ab_cdef;
        b = va[2:0] ^ {3{processor_endian_flag}};
        e = f[2] ? EXC_TLB_REFILL : (f[1] ? EXC_TLB_INVALID : EXC_BUS);
        pv = 1'b0;
        if (op == OP_JUMP_VIA_REGISTER || op == OP_JUMP_REG_WITH_LINK) begin
            push(1, {|a[1:0], a});
            res = req_in.pc + LINK_OFFSET;
            pv = (op == OP_JUMP_REG_WITH_LINK);
            if (pv) push(2, {dest, res});
        end else if ((op == OP_LOAD_DOUBLEWORD || op == OP_LOAD_DWORD_TO_COP) &&
                     va[2:0] != 3'h0) begin
            push(5, {EXC_ADDR_LOAD, va});
        end else begin
            busy = 1'b1;
            sz = SIZE_DWORD;
            mo = 3'h0;
            case (op)
                OP_LOAD_SIGNED_BYTE, OP_LOAD_UNSIGNED_BYTE: begin
                    sz = SIZE_BYTE;
                    mo = va[2:0];
                end
                OP_UNALIGNED_LOAD_LEFT: begin
                    sz = b;
                    mo = memory_endian_flag ? ~b : 3'h0;
                end
                OP_UNALIGNED_LOAD_RIGHT: begin
                    sz = ~b;
                    mo = memory_endian_flag ? 3'h0 : b;
                end
                default: ;
            endcase
            push(3, {va, sz, mo});
            res = d >> {b, 3'h0};
            case (op)
                OP_LOAD_SIGNED_BYTE: res = {{56{res[7]}}, res[7:0]};
                OP_LOAD_UNSIGNED_BYTE: res = {56'h0, res[7:0]};
                OP_UNALIGNED_LOAD_LEFT: res = (d << {~b, 3'h0}) |
                    (old & ((64'h1 << {~b, 3'h0}) - 64'h1));
                OP_UNALIGNED_LOAD_RIGHT: res = res | (old & ~(~64'h0 >> {b, 3'h0}));
                default: res = d;
            endcase
            if (f != 3'h0) begin
                push(5, {e, (e == EXC_BUS) ? 64'h0 : va});
            end else if (op == OP_LOAD_DWORD_TO_COP) begin
                push(4, {cs, d});
            end else begin
                push(2, {dest, res});
                pv = 1'b1;
            end
        end
        pd = dest;
        pdat = res;
        req_valid_in = 1'b1;
        @(posedge clk_in);
        #1;
        // only a load that went to memory may hold off the next request
        check(ready_out, !busy);
    endtask : issue

    // ====================================================
    // scenarios
    initial begin
        jrl_op_t op;
        logic [4:0] dest;
        logic [15:0] off;
        logic [63:0] a;
        void'($urandom(69));
        repeat (20) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        // link into the default return register, then merge onto it at once
        issue(OP_JUMP_REG_WITH_LINK, LINK_REG_DEFAULT, 64'h40, 16'h0, 2'h1);
        issue(OP_UNALIGNED_LOAD_LEFT, LINK_REG_DEFAULT, 64'h1003, 16'h0, 2'h1);
        issue(OP_JUMP_VIA_REGISTER, 5'h2, 64'h82, 16'h0, 2'h1);
        for (int i = 0; i < 400; i++) begin
            op = jrl_op_t'(3'($urandom));
            dest = 5'($urandom % 4);
            if (op == OP_LOAD_DWORD_TO_COP) dest[0] = 1'b0;
            off = 16'($urandom);
            a = {$urandom, $urandom};
            if ($urandom % 2 == 0) begin
                off[2:0] = 3'h0;
                a[2:0] = 3'h0;
            end
            issue(op, dest, a, off, 2'($urandom % 3 + 1));
            if ($urandom % 8 == 0) idle(1);
        end
        idle(8);
        check(exp_q.size(), 0);
        report_and_stop();
    end

    initial begin
        #2_000_000;
        num_errors++;
        report_and_stop();
    end
endmodule : testbench
